// File: core/capture_pkg.sv
// constants and carrier types for the input capture channel
// assumes a 16-bit register port with one cycle read latency
package capture_pkg;
    // register offsets (word index on the plain port)
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_BUFFER  = 3'h1;
    localparam logic [2:0] ADDR_STATUS  = 3'h2;
    localparam logic [2:0] ADDR_MASK    = 3'h3;
    // control field positions
    localparam int IDLE_STOP_BIT  = 13;
    localparam int TIMEBASE_BIT   = 7;
    localparam int CPI_HI         = 6;
    localparam int CPI_LO         = 5;
    localparam int OVERFLOW_BIT   = 4;
    localparam int NONEMPTY_BIT   = 3;
    localparam int MODE_HI        = 2;
    localparam int MODE_LO        = 0;
    // writable control bits; flags are hardware-owned
    localparam logic [15:0] CONTROL_WMASK  = 16'h20e7;
    localparam logic [15:0] CONTROL_RESET  = 16'h0000;
    localparam logic [2:0]  STATUS_RESET   = 3'h0;
    localparam int          BUFFER_DEPTH   = 4;
    // status/mask bit positions
    localparam int EV_CAPTURE  = 0;
    localparam int EV_OVERFLOW = 1;
    localparam int EV_WAKE     = 2;
    // capture modes
    localparam logic [2:0] MODE_OFF     = 3'h0;
    localparam logic [2:0] MODE_EVERY   = 3'h1;
    localparam logic [2:0] MODE_FALL    = 3'h2;
    localparam logic [2:0] MODE_RISE    = 3'h3;
    localparam logic [2:0] MODE_RISE4   = 3'h4;
    localparam logic [2:0] MODE_RISE16  = 3'h5;
    localparam logic [2:0] MODE_UNUSED  = 3'h6;
    localparam logic [2:0] MODE_WAKE    = 3'h7;
    localparam logic [3:0] PRESCALE4    = 4'h3;
    localparam logic [3:0] PRESCALE16   = 4'hf;

    typedef enum logic [1:0] {
        RUN_ACTIVE = 2'b01,
        RUN_HALTED = 2'b10
    } run_e;

    typedef struct packed {
        logic [2:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_s;
endpackage

// File: core/input_capture_channel.sv
// one input capture channel with four-deep capture buffer and interrupt
// assumes async pin input, timer counts on clk, cpu idle/sleep levels on clk
// Behaviour
// R1: idle-stop bit halts channel during cpu idle
// R2: timebase set captures timer b count
// R3: two-bit field sets captures per interrupt
// R4: overflow flag read-only, set on overflow
// R5: mode 000 turns channel off
// R6: mode 001 every edge, ignores per-irq field
// R7: mode 010 captures falling edges only
// R8: mode 011 captures rising edges only
// R9: mode 100 captures every fourth rise
// R10: mode 101 captures every sixteenth rise
// R11: mode 110 unused, behaves as disabled
// R12: mode 111 rising edge wake interrupt only
// R13: nonempty flag shows unread buffer data
// R14: timebase clear captures timer c count
// R15: code 10 interrupts every third capture
`timescale 1ns/1ps
`default_nettype none
module input_capture_channel (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    capture_pin,
    input  wire logic [15:0]             timer_b_count,
    input  wire logic [15:0]             timer_c_count,
    input  wire logic                    cpu_idle,
    input  wire logic                    cpu_sleep,
    input  wire capture_pkg::bus_req_s   bus,
    output logic      [15:0]             rdata,
    output logic                         irq
);
    localparam int DEPTH = capture_pkg::BUFFER_DEPTH;

    typedef struct packed {
        logic [1:0]        pin_sync;
        logic              pin_prev;
        logic [15:0]       control;
        logic [DEPTH-1:0][15:0] buffer;
        logic [2:0]        count;
        logic [3:0]        prescale;
        logic [1:0]        irq_div;
        logic              overflow;
        logic [2:0]        status;
        logic [2:0]        mask;
        capture_pkg::run_e run;
        logic [15:0]       rdata;
        logic              irq;
    } state_s;

    state_s st;
    state_s next_st;

    // captures per interrupt minus one; code 10 taken as three
    function automatic logic [1:0] irq_period(input logic [1:0] code);
        case (code)
            2'h0:    irq_period = 2'h0;
            2'h1:    irq_period = 2'h1;
            2'h2:    irq_period = 2'h2; // R15
            default: irq_period = 2'h3; // R3
        endcase
    endfunction

    logic [2:0]  mode;
    logic [1:0]  cpi;
    logic        rise;
    logic        fall;
    logic        capture;
    logic        capture_irq;
    logic        wake;
    logic        halted;
    logic [15:0] stamp;
    logic        pop;
    logic [2:0]  events;

    // edge detect only on the second sync stage, never the first
    always_comb
    begin
        mode   = st.control[capture_pkg::MODE_HI:capture_pkg::MODE_LO];
        cpi    = st.control[capture_pkg::CPI_HI:capture_pkg::CPI_LO];
        rise   = st.pin_sync[1] & ~st.pin_prev;
        fall   = ~st.pin_sync[1] & st.pin_prev;
        halted = (st.run == capture_pkg::RUN_HALTED);
        stamp  = st.control[capture_pkg::TIMEBASE_BIT] ? timer_b_count // R2
                                                        : timer_c_count; // R14
        pop    = bus.rd && bus.addr == capture_pkg::ADDR_BUFFER && st.count != 3'h0;
    end

    // capture event selection per mode
    always_comb
    begin
        capture = 1'b0;
        wake    = 1'b0;
        if (!halted)
        begin
            case (mode)
                capture_pkg::MODE_EVERY:  capture = rise | fall; // R6
                capture_pkg::MODE_FALL:   capture = fall; // R7
                capture_pkg::MODE_RISE:   capture = rise; // R8
                capture_pkg::MODE_RISE4:  capture = rise && st.prescale[1:0] == 2'h3; // R9
                capture_pkg::MODE_RISE16: capture = rise && st.prescale == capture_pkg::PRESCALE16; // R10
                default:                  capture = 1'b0; // R5 R11
            endcase
        end
        // wake source ignores idle-stop and every control bit except the mode field
        if (mode == capture_pkg::MODE_WAKE)
            wake = rise && (cpu_sleep || cpu_idle); // R12
        // every-edge mode interrupts on each capture
        if (mode == capture_pkg::MODE_EVERY)
            capture_irq = capture; // R6
        else
            capture_irq = capture && st.irq_div == irq_period(cpi); // R3
    end

    always_comb
    begin
        next_st = st;
        next_st.pin_sync = {st.pin_sync[0], capture_pin};
        next_st.pin_prev = st.pin_sync[1];
        events = 3'h0;

        // halt in idle only when idle-stop is set
        if (cpu_idle && st.control[capture_pkg::IDLE_STOP_BIT])
            next_st.run = capture_pkg::RUN_HALTED; // R1
        else
            next_st.run = capture_pkg::RUN_ACTIVE; // R1

        // prescaler counts rises only in the divided modes
        if (mode != capture_pkg::MODE_RISE4 && mode != capture_pkg::MODE_RISE16)
            next_st.prescale = 4'h0;
        else if (rise && !halted)
            next_st.prescale = st.prescale + 4'h1; // R9 R10

        if (capture)
        begin
            if (capture_irq)
                next_st.irq_div = 2'h0;
            else
                next_st.irq_div = st.irq_div + 2'h1; // R3
        end
        // disabled modes restart the interrupt divider
        if (mode == capture_pkg::MODE_OFF || mode == capture_pkg::MODE_UNUSED)
            next_st.irq_div = 2'h0; // R5 R11

        // buffer pop, then push; a full buffer drops the new value
        if (pop)
        begin
            for (int i = 0; i < DEPTH - 1; i++)
                next_st.buffer[i] = st.buffer[i + 1];
            next_st.count = st.count - 3'h1;
        end
        if (capture)
        begin
            if (st.count == 3'(DEPTH) && !pop)
            begin
                next_st.overflow = 1'b1; // R4
                events[capture_pkg::EV_OVERFLOW] = 1'b1;
            end
            else
            begin
                next_st.buffer[next_st.count[1:0]] = stamp;
                next_st.count = next_st.count + 3'h1;
            end
        end
        // overflow clears in hardware once the buffer drains
        if (st.overflow && st.count == 3'h0 && !capture)
            next_st.overflow = 1'b0; // R4

        events[capture_pkg::EV_CAPTURE] = capture_irq;
        events[capture_pkg::EV_WAKE]    = wake; // R12

        // register writes; flags stay hardware-owned
        if (bus.wr)
        begin
            case (bus.addr)
                capture_pkg::ADDR_CONTROL:
                begin
                    // a new setting restarts both counts so a stale count
                    // never shortens the spacing; a capture in this cycle is not counted
                    next_st.control  = bus.wdata & capture_pkg::CONTROL_WMASK; // R4
                    next_st.prescale = 4'h0; // R9 R10
                    next_st.irq_div  = 2'h0; // R3
                end
                capture_pkg::ADDR_STATUS:
                    next_st.status = st.status & ~bus.wdata[2:0];
                capture_pkg::ADDR_MASK:
                    next_st.mask = bus.wdata[2:0];
                default: ;
            endcase
        end
        // set wins over a clear in the same cycle
        next_st.status = next_st.status | events;

        // read data one cycle later
        next_st.rdata = 16'h0000;
        if (bus.rd)
        begin
            case (bus.addr)
                capture_pkg::ADDR_CONTROL:
                begin
                    next_st.rdata = st.control;
                    next_st.rdata[capture_pkg::OVERFLOW_BIT] = st.overflow; // R4
                    next_st.rdata[capture_pkg::NONEMPTY_BIT] = st.count != 3'h0; // R13
                end
                capture_pkg::ADDR_BUFFER:
                    next_st.rdata = (st.count != 3'h0) ? st.buffer[0] : 16'h0000;
                capture_pkg::ADDR_STATUS:
                    next_st.rdata = {13'h0000, st.status};
                capture_pkg::ADDR_MASK:
                    next_st.rdata = {13'h0000, st.mask};
                default:
                    next_st.rdata = 16'h0000;
            endcase
        end
        next_st.irq = |(next_st.status & next_st.mask);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st          <= '0;
            st.control  <= capture_pkg::CONTROL_RESET;
            st.status   <= capture_pkg::STATUS_RESET;
            st.run      <= capture_pkg::RUN_ACTIVE;
        end
        else
            st <= next_st;
    end

    assign rdata = st.rdata;
    assign irq   = st.irq;

    // checks beside the logic they guard
    sequence s_rise_seen;
        st.pin_sync[1] && !st.pin_prev;
    endsequence

    AST_IDLE_HALT: assert property (@(posedge clk) disable iff (rst) // R1
        halted && mode != capture_pkg::MODE_WAKE |-> !capture)
        else $error("capture while halted in idle");
    AST_TIMEBASE: assert property (@(posedge clk) disable iff (rst) // R2
        capture && st.count == 3'h0 && st.control[capture_pkg::TIMEBASE_BIT]
        |=> st.buffer[0] == $past(timer_b_count))
        else $error("timer b count not captured");
    AST_TIMEBASE_C: assert property (@(posedge clk) disable iff (rst) // R14
        capture && st.count == 3'h0 && !st.control[capture_pkg::TIMEBASE_BIT]
        |=> st.buffer[0] == $past(timer_c_count))
        else $error("timer c count not captured");
    AST_OVERFLOW: assert property (@(posedge clk) disable iff (rst) // R4
        capture && !pop && st.count == 3'(DEPTH) |=> st.overflow)
        else $error("overflow not flagged");
    AST_OFF: assert property (@(posedge clk) disable iff (rst) // R5
        mode == capture_pkg::MODE_OFF || mode == capture_pkg::MODE_UNUSED |-> !capture)
        else $error("capture in disabled mode");
    AST_FALL_ONLY: assert property (@(posedge clk) disable iff (rst) // R7
        (mode == capture_pkg::MODE_FALL) and s_rise_seen |-> !capture)
        else $error("rising edge captured in falling mode");
    AST_RISE: assert property (@(posedge clk) disable iff (rst) // R8
        (mode == capture_pkg::MODE_RISE && !halted) and s_rise_seen |-> capture)
        else $error("rising edge missed");
    AST_EVERY_IRQ: assert property (@(posedge clk) disable iff (rst) // R6
        mode == capture_pkg::MODE_EVERY && capture |=> st.status[capture_pkg::EV_CAPTURE])
        else $error("every-edge capture did not flag");
    AST_WAKE: assert property (@(posedge clk) disable iff (rst) // R12
        mode == capture_pkg::MODE_WAKE |-> !capture)
        else $error("capture in wake mode");
    AST_NONEMPTY: assert property (@(posedge clk) disable iff (rst) // R13
        bus.rd && bus.addr == capture_pkg::ADDR_CONTROL
        |=> rdata[capture_pkg::NONEMPTY_BIT] == ($past(st.count) != 3'h0))
        else $error("nonempty flag wrong");
    AST_DIV4: assert property (@(posedge clk) disable iff (rst) // R9
        capture && mode == capture_pkg::MODE_RISE4 |-> st.prescale[1:0] == 2'h3)
        else $error("divide by four wrong");
    AST_DIV16: assert property (@(posedge clk) disable iff (rst) // R10
        capture && mode == capture_pkg::MODE_RISE16 |-> st.prescale == 4'hf)
        else $error("divide by sixteen wrong");
    AST_CPI: assert property (@(posedge clk) disable iff (rst) // R3
        capture && mode == capture_pkg::MODE_RISE && cpi == 2'h0 |-> capture_irq)
        else $error("per-capture interrupt missing");
    AST_CPI3: assert property (@(posedge clk) disable iff (rst) // R15
        capture_irq && mode != capture_pkg::MODE_EVERY && cpi == 2'h2
        |-> st.irq_div == 2'h2)
        else $error("third capture interrupt wrong");

    // multi-step behaviour: falling edge, wake edge, full buffer, two-capture cadence
    sequence s_fall_seen;
        !st.pin_sync[1] && st.pin_prev;
    endsequence

    sequence s_wake_edge;
        mode == capture_pkg::MODE_WAKE && (cpu_sleep || cpu_idle) ##0 s_rise_seen;
    endsequence

    sequence s_push_full;
        capture && !pop && st.count == 3'(DEPTH);
    endsequence

    sequence s_cpi_two_first;
        capture && mode == capture_pkg::MODE_RISE && cpi == 2'h1 && st.irq_div == 2'h0;
    endsequence

    AST_FALL: assert property (@(posedge clk) disable iff (rst) // R7
        (mode == capture_pkg::MODE_FALL && !halted) and s_fall_seen |-> capture)
        else $error("falling edge missed");
    AST_WAKE_FLAG: assert property (@(posedge clk) disable iff (rst) // R12
        s_wake_edge |=> st.status[capture_pkg::EV_WAKE])
        else $error("wake edge not flagged");
    // a full buffer keeps its oldest words and drops the new one
    AST_FULL_KEEP: assert property (@(posedge clk) disable iff (rst) // R4
        s_push_full |=> st.count == 3'(DEPTH) && st.buffer == $past(st.buffer))
        else $error("full buffer overwritten");
    AST_CPI2: assert property (@(posedge clk) disable iff (rst) // R3
        s_cpi_two_first |-> !capture_irq)
        else $error("first of two captures interrupted");
    // software may not touch the overflow flag
    AST_OV_READONLY: assert property (@(posedge clk) disable iff (rst) // R4
        bus.wr && bus.addr == capture_pkg::ADDR_CONTROL && !capture && st.count != 3'h0
        |=> st.overflow == $past(st.overflow))
        else $error("overflow flag changed by write");
    AST_OV_CLEAR: assert property (@(posedge clk) disable iff (rst) // R4
        st.overflow && st.count == 3'h0 && !capture |=> !st.overflow)
        else $error("overflow flag stuck after drain");
    // reading an empty buffer answers zero and pops nothing
    AST_EMPTY_READ: assert property (@(posedge clk) disable iff (rst) // R13
        bus.rd && bus.addr == capture_pkg::ADDR_BUFFER && st.count == 3'h0
        |=> rdata == 16'h0000)
        else $error("empty buffer read not zero");
    AST_POP: assert property (@(posedge clk) disable iff (rst) // R13
        pop && !capture |=> st.count == $past(st.count) - 3'h1)
        else $error("buffer read did not pop");
    // idle without idle-stop keeps running; halted idle freezes the prescaler
    AST_IDLE_RUN: assert property (@(posedge clk) disable iff (rst) // R1
        cpu_idle && !st.control[capture_pkg::IDLE_STOP_BIT] |=> !halted)
        else $error("halted in idle without idle-stop");
    AST_HALT_FREEZE: assert property (@(posedge clk) disable iff (rst) // R1
        halted && !bus.wr |=> $stable(st.prescale))
        else $error("prescaler moved while halted");
    // undivided modes hold the prescaler at zero for a clean start
    AST_PRESCALE_REST: assert property (@(posedge clk) disable iff (rst) // R9
        mode != capture_pkg::MODE_RISE4 && mode != capture_pkg::MODE_RISE16
        |=> st.prescale == 4'h0)
        else $error("prescaler moved in undivided mode");
    AST_OFF_DIV: assert property (@(posedge clk) disable iff (rst) // R5
        mode == capture_pkg::MODE_OFF |=> st.irq_div == 2'h0)
        else $error("divider moved while off");
    AST_UNUSED_DIV: assert property (@(posedge clk) disable iff (rst) // R11
        mode == capture_pkg::MODE_UNUSED |=> st.irq_div == 2'h0)
        else $error("divider moved in unused mode");
endmodule
`default_nettype wire

// File: verification/pin_timer_model.sv
// stand-in for the capture pin and the two timer counts
// assumes one-cycle toggle requests from the bench on clk
`timescale 1ns/1ps
`default_nettype none
module pin_timer_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        toggle,
    output logic             pin,
    output logic      [15:0] count_b,
    output logic      [15:0] count_c
);
    logic [15:0] base;
    // timers step with the pin so every edge carries a known stamp
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin  <= 1'b0;
            base <= 16'h0000;
        end
        else if (toggle)
        begin
            pin  <= ~pin;
            base <= base + 16'h0101;
        end
    end
    assign count_b = base;
    assign count_c = ~base; // differs from b in every bit
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the input capture channel
// assumes pin_timer_model drives the pin and both timers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [15:0] ctl;
        logic        idle;
        logic        sleep;
        logic [4:0]  pulses;
        logic [2:0]  ncap;
        logic [1:0]  ftog;
        logic [2:0]  st;
    } row_s;
    logic                  clk;
    logic                  rst;
    logic                  toggle;
    logic                  cpu_idle;
    logic                  cpu_sleep;
    capture_pkg::bus_req_s bus;
    wire logic             pin;
    wire logic [15:0]      cnt_b;
    wire logic [15:0]      cnt_c;
    wire logic [15:0]      rdata;
    wire logic             irq;
    logic [15:0]           d;
    logic [15:0]           stamp;
    int                    err_count;
    int                    n_checks;
    int                    cnt;
    row_s                  rows [11];
    row_s                  ovr;

    pin_timer_model i_ptm (.clk(clk), .rst(rst), .toggle(toggle), .pin(pin),
        .count_b(cnt_b), .count_c(cnt_c));
    input_capture_channel i_dut (.clk(clk), .rst(rst), .capture_pin(pin),
        .timer_b_count(cnt_b), .timer_c_count(cnt_c), .cpu_idle(cpu_idle),
        .cpu_sleep(cpu_sleep), .bus(bus), .rdata(rdata), .irq(irq));

    // clock generation
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic close_out();
        if (err_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reset_dut();
        @(posedge clk);
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
    endtask

    // bus cycles: strobe lasts exactly one edge
    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge clk);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        bus <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata; // read data stand only this cycle
    endtask

    // one pin edge, then room for the sync delay
    task automatic flip(input int k, input row_s r);
        @(posedge clk);
        toggle <= 1'b1;
        @(posedge clk);
        toggle <= 1'b0;
        #1 if (k == r.ftog) stamp = r.ctl[7] ? cnt_b : cnt_c;
        repeat (8) @(posedge clk);
    endtask

    task automatic run_row(input row_s r);
        cpu_idle <= r.idle;
        cpu_sleep <= r.sleep;
        wr(capture_pkg::ADDR_CONTROL, r.ctl);
        wr(capture_pkg::ADDR_STATUS, 16'h0007);
        for (int k = 1; k <= 2 * r.pulses; k++)
            flip(k, r);
        cpu_idle <= 1'b0;
        cpu_sleep <= 1'b0;
        rd(capture_pkg::ADDR_STATUS);
        chk("status", {13'h0, r.st}, d);
        chk("irq", {15'h0, r.st != 3'h0}, {15'h0, irq});
        cnt = 0;
        // drain while the nonempty flag says data remain
        repeat (5)
        begin
            rd(capture_pkg::ADDR_CONTROL);
            if (d[3] === 1'b1)
            begin
                rd(capture_pkg::ADDR_BUFFER);
                if (cnt == 0 && r.ftog != 2'h0) chk("first capture", stamp, d);
                cnt++;
            end
        end
        chk("captures", 16'(r.ncap), 16'(cnt));
    endtask

    initial
    begin
        repeat (30000) @(posedge clk);
        err_count++;
        close_out();
    end

    // main sequence
    initial
    begin
        rst = 1'b1;
        toggle = 1'b0;
        bus = '0;
        cpu_idle = 1'b0;
        cpu_sleep = 1'b0;
        err_count = 0;
        n_checks = 0;
        rows = '{'{16'h0000, 1'b0, 1'b0, 5'd2, 3'd0, 2'd0, 3'h0},
                 '{16'h00e1, 1'b0, 1'b0, 5'd1, 3'd2, 2'd1, 3'h1},
                 '{16'h0002, 1'b0, 1'b0, 5'd2, 3'd2, 2'd2, 3'h1},
                 '{16'h0083, 1'b0, 1'b0, 5'd2, 3'd2, 2'd1, 3'h1},
                 '{16'h0084, 1'b0, 1'b0, 5'd8, 3'd2, 2'd0, 3'h1},
                 '{16'h0085, 1'b0, 1'b0, 5'd16, 3'd1, 2'd0, 3'h1},
                 '{16'h0006, 1'b0, 1'b0, 5'd2, 3'd0, 2'd0, 3'h0},
                 '{16'h2083, 1'b1, 1'b0, 5'd2, 3'd0, 2'd0, 3'h0},
                 '{16'h0083, 1'b1, 1'b0, 5'd2, 3'd2, 2'd1, 3'h1},
                 '{16'h0007, 1'b0, 1'b1, 5'd1, 3'd0, 2'd0, 3'h4},
                 '{16'h0007, 1'b0, 1'b0, 5'd1, 3'd0, 2'd0, 3'h0}};
        ovr = '{16'h0081, 1'b0, 1'b0, 5'd3, 3'd4, 2'd1, 3'h3};
        reset_dut();
        rd(capture_pkg::ADDR_CONTROL);
        chk("control reset", capture_pkg::CONTROL_RESET, d);
        wr(capture_pkg::ADDR_CONTROL, 16'hffff);
        rd(capture_pkg::ADDR_CONTROL);
        chk("control write", capture_pkg::CONTROL_WMASK, d);
        wr(capture_pkg::ADDR_MASK, 16'h0007);
        foreach (rows[i])
            run_row(rows[i]);
        // overflow: six captures into a four-deep buffer
        wr(capture_pkg::ADDR_CONTROL, ovr.ctl);
        for (int k = 1; k <= 6; k++)
            flip(k, ovr);
        rd(capture_pkg::ADDR_CONTROL);
        chk("overflow control", 16'h0099, d);
        rd(capture_pkg::ADDR_STATUS);
        chk("overflow status", 16'h0003, d);
        rd(capture_pkg::ADDR_BUFFER);
        chk("oldest kept", stamp, d);
        repeat (3) rd(capture_pkg::ADDR_BUFFER);
        rd(capture_pkg::ADDR_CONTROL);
        chk("drained control", 16'h0081, d);
        rd(capture_pkg::ADDR_BUFFER);
        chk("empty buffer", 16'h0000, d);
        // masking and write-one clear
        wr(capture_pkg::ADDR_MASK, 16'h0000);
        rd(capture_pkg::ADDR_MASK);
        chk("masked irq", 16'h0000, {15'h0, irq});
        chk("mask read", 16'h0000, d);
        wr(capture_pkg::ADDR_MASK, 16'h0007);
        rd(capture_pkg::ADDR_MASK);
        chk("unmasked irq", 16'h0001, {15'h0, irq});
        wr(capture_pkg::ADDR_STATUS, 16'h0007);
        rd(capture_pkg::ADDR_STATUS);
        chk("cleared status", 16'h0000, d);
        chk("cleared irq", 16'h0000, {15'h0, irq});
        wr(3'h5, 16'hffff);
        rd(3'h7);
        chk("unmapped", 16'h0000, d);
        // captures per interrupt, each code from a fresh reset
        for (int c = 0; c < 4; c++)
        begin
            reset_dut();
            wr(capture_pkg::ADDR_MASK, 16'h0007);
            wr(capture_pkg::ADDR_CONTROL, 16'h0083 | 16'(c << 5));
            for (int k = 1; k <= c + 1; k++)
            begin
                flip(0, ovr);
                flip(0, ovr);
                rd(capture_pkg::ADDR_STATUS);
                chk("per irq status", {15'h0, k == c + 1}, d);
            end
        end
        close_out();
    end
endmodule
`default_nettype wire
